// File: verilog/e1_tx_pkg.sv
/*
 * Shared constants and carriers for the E1 transmit frame assembler.
 * Assumes a 25 MHz system clock that oversamples the 2048 kHz bus clock.
 */
package e1_tx_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus framing
    localparam int CHANNELS = 32;
    localparam int BITS_PER_CHANNEL = 8;
    localparam int POS_W = 8;
    localparam logic [7:0] POS_FIRST = 8'h00;
    localparam logic [7:0] POS_STEP = 8'h01;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [4:0] TS_SYNC = 5'h00;
    localparam logic [4:0] TS_SIG = 5'h10;
    localparam logic [4:0] CH_CTL_CCS = 5'h1F;
    localparam int CCS_BIT = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Timeslot 0 content
    localparam logic [6:0] FAS_WORD = 7'h1B;
    localparam logic [5:0] MFAS_WORD = 6'h0B;
    localparam logic [3:0] FRAME_FIRST = 4'h0;
    localparam logic [3:0] FRAME_STEP = 4'h1;
    localparam logic [3:0] FRAME_MFAS_END = 4'hC;
    localparam logic [3:0] FRAME_REPORT_1 = 4'hD;
    localparam logic [3:0] FRAME_RESET = 4'hF;
    localparam logic [2:0] MFAS_TOP = 3'h5;
    localparam logic [1:0] CRC_TOP = 2'h3;
    localparam logic [3:0] CRC_INIT = 4'h0;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [7:0] UNUSED_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic bitClock;
        logic framePulseN;
        logic data;
        logic ctl0;
        logic ctl1;
    } bus_in_s;

    typedef struct packed {
        logic data;
        logic mfStart;
        logic ts0;
    } line_out_s;

endpackage

// File: verilog/e1_crc4_tx_frame_assembler.sv
/*
 * E1 transmit frame assembler: takes serial bus streams, builds the line
 * frame with timeslot 0 framing, CRC-4 and far-end report bits.
 * Assumes all bus pins are asynchronous to clk, and that the far-end report
 * inputs come from logic on clk. Line slot k is sent during bus channel k+1.
 */
`timescale 1ns/1ns
module e1_crc4_tx_frame_assembler (
    input wire logic clk,
    input wire logic rst,
    input wire logic busBitClockIn,
    input wire logic framePulseInN,
    input wire logic dataStreamIn,
    input wire logic controlStreamFirstIn,
    input wire logic controlStreamSecondIn,
    input wire logic farEndReportFirst,
    input wire logic farEndReportSecond,
    input wire logic remoteAlarm,
    input wire logic [4:0] nationalUseBits,
    output e1_tx_pkg::line_out_s lineOut,
    output logic lineBitStrobe,
    output logic ccsModeActive
);

    ////////////////////////////////////////////////////////////////////////////
    // CRC-4 serial step, top bit shifts out and folds back as x+1
    function automatic logic [3:0] crcStep(input logic [3:0] c, input logic b);
        logic fb;
        fb = b ^ c[3];
        return {c[2:0], 1'b0} ^ {2'b00, fb, fb};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input group: synchronisers, bit position, channel capture
    e1_tx_pkg::bus_in_s pinIn;
    e1_tx_pkg::bus_in_s sync1_q, sync2_q, syncPrev_q;
    logic [e1_tx_pkg::POS_W-1:0] bitPos_q, bitPos_d;
    logic [7:0] dataSh_q, dataSh_d, ctl0Sh_q, ctl0Sh_d, ctl1Sh_q, ctl1Sh_d;
    logic [7:0] dataShD, ctl0ShD, ctl1ShD;
    logic [7:0] nextByte_q, nextByte_d;
    logic [4:0] nextSlot_q, nextSlot_d, busChan;
    logic byteDone_q, byteDone_d, ccsMode_q, ccsMode_d;
    logic fallEdge, riseEdge, fpActive;

    assign pinIn = '{bitClock: busBitClockIn, framePulseN: framePulseInN,
                     data: dataStreamIn, ctl0: controlStreamFirstIn,
                     ctl1: controlStreamSecondIn};
    assign fallEdge = syncPrev_q.bitClock & ~sync2_q.bitClock;
    assign riseEdge = ~syncPrev_q.bitClock & sync2_q.bitClock;
    assign fpActive = ~sync2_q.framePulseN;
    assign dataShD = {dataSh_q[6:0], sync2_q.data};
    assign ctl0ShD = {ctl0Sh_q[6:0], sync2_q.ctl0};
    assign ctl1ShD = {ctl1Sh_q[6:0], sync2_q.ctl1};
    assign busChan = bitPos_q[7:3];

    // Next values of the capture side, all work done on the bit clock fall
    always_comb begin
        bitPos_d = bitPos_q;
        dataSh_d = dataSh_q;
        ctl0Sh_d = ctl0Sh_q;
        ctl1Sh_d = ctl1Sh_q;
        nextByte_d = nextByte_q;
        nextSlot_d = nextSlot_q;
        byteDone_d = 1'b0;
        ccsMode_d = ccsMode_q;
        if (fallEdge) begin
            dataSh_d = dataShD;
            ctl0Sh_d = ctl0ShD;
            ctl1Sh_d = ctl1ShD;
            // Pulse marks boundary; 8-bit wrap gives 32 channels of 8 bits
            bitPos_d = fpActive ? e1_tx_pkg::POS_FIRST : bitPos_q + e1_tx_pkg::POS_STEP;
            if (bitPos_q[2:0] == e1_tx_pkg::LAST_BIT) begin
                byteDone_d = 1'b1;
                nextSlot_d = busChan;
                if (busChan == e1_tx_pkg::TS_SIG) begin
                    nextByte_d = ccsMode_q ? dataShD : ctl1ShD;
                end else if (busChan == e1_tx_pkg::TS_SYNC) begin
                    nextByte_d = e1_tx_pkg::UNUSED_BYTE;
                end else begin
                    nextByte_d = dataShD;
                end
                if (busChan == e1_tx_pkg::CH_CTL_CCS) begin
                    ccsMode_d = ctl0ShD[e1_tx_pkg::CCS_BIT];
                end
            end
        end
    end

    // Registers of the capture side
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '1;
            sync2_q <= '1;
            syncPrev_q <= '1;
            bitPos_q <= e1_tx_pkg::POS_FIRST;
            dataSh_q <= e1_tx_pkg::UNUSED_BYTE;
            ctl0Sh_q <= e1_tx_pkg::UNUSED_BYTE;
            ctl1Sh_q <= e1_tx_pkg::UNUSED_BYTE;
            nextByte_q <= e1_tx_pkg::IDLE_BYTE;
            nextSlot_q <= e1_tx_pkg::TS_SIG;
            byteDone_q <= 1'b0;
            ccsMode_q <= 1'b0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            syncPrev_q <= sync2_q;
            bitPos_q <= bitPos_d;
            dataSh_q <= dataSh_d;
            ctl0Sh_q <= ctl0Sh_d;
            ctl1Sh_q <= ctl1Sh_d;
            nextByte_q <= nextByte_d;
            nextSlot_q <= nextSlot_d;
            byteDone_q <= byteDone_d;
            ccsMode_q <= ccsMode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output group: timeslot 0 build, line shifter, CRC-4
    logic loadArm_q, loadArm_d;
    logic [7:0] outSh_q, outSh_d, ts0Byte, loadByte;
    logic [4:0] lineSlot_q, lineSlot_d;
    logic [3:0] lineFrame_q, lineFrame_d, newFrame, crc_q, crc_d, crcHold_q, crcHold_d;
    logic [3:0] crcBase;
    e1_tx_pkg::line_out_s lineOut_q, lineOut_d;
    logic slot0, smfStart, cBit, oddBit1, outBitVal, isCbit;

    assign slot0 = nextSlot_q == e1_tx_pkg::TS_SYNC;
    assign newFrame = lineFrame_q + e1_tx_pkg::FRAME_STEP;
    assign smfStart = newFrame[2:0] == e1_tx_pkg::FRAME_FIRST[2:0];

    // Timeslot 0 word for the frame about to start
    always_comb begin
        // Start of a submultiframe takes the fresh remainder directly
        cBit = smfStart ? crc_q[3] : crcHold_q[e1_tx_pkg::CRC_TOP - newFrame[2:1]];
        if (newFrame < e1_tx_pkg::FRAME_MFAS_END) begin
            oddBit1 = e1_tx_pkg::MFAS_WORD[e1_tx_pkg::MFAS_TOP - newFrame[3:1]];
        end else if (newFrame == e1_tx_pkg::FRAME_REPORT_1) begin
            oddBit1 = farEndReportFirst;
        end else begin
            oddBit1 = farEndReportSecond;
        end
        if (!newFrame[0]) begin
            ts0Byte = {cBit, e1_tx_pkg::FAS_WORD};
        end else begin
            ts0Byte = {oddBit1, 1'b1, remoteAlarm, nationalUseBits};
        end
        loadByte = slot0 ? ts0Byte : nextByte_q;
    end

    // Next values of the line side, work done on the bit clock rise except arming the load on byteDone_q
    always_comb begin
        loadArm_d = loadArm_q;
        outSh_d = outSh_q;
        lineSlot_d = lineSlot_q;
        lineFrame_d = lineFrame_q;
        crc_d = crc_q;
        crcHold_d = crcHold_q;
        lineOut_d = lineOut_q;
        outBitVal = outSh_q[7];
        isCbit = 1'b0;
        crcBase = crc_q;
        if (riseEdge) begin
            if (loadArm_q) begin
                loadArm_d = 1'b0;
                outBitVal = loadByte[7];
                outSh_d = {loadByte[6:0], 1'b1};
                lineSlot_d = nextSlot_q;
                if (slot0) begin
                    lineFrame_d = newFrame;
                    isCbit = ~newFrame[0];
                    if (smfStart) begin
                        crcHold_d = crc_q;
                        crcBase = e1_tx_pkg::CRC_INIT;
                    end
                end
            end else begin
                outSh_d = {outSh_q[6:0], 1'b1};
            end
            crc_d = crcStep(crcBase, isCbit ? 1'b0 : outBitVal);
            lineOut_d.data = outBitVal;
            lineOut_d.ts0 = lineSlot_d == e1_tx_pkg::TS_SYNC;
            lineOut_d.mfStart = loadArm_q && slot0 && newFrame == e1_tx_pkg::FRAME_FIRST;
        end
        // A byte finished on the fall wins over the clear
        if (byteDone_q) begin
            loadArm_d = 1'b1;
        end
    end

    // Registers of the line side
    always_ff @(posedge clk) begin
        if (rst) begin
            loadArm_q <= 1'b0;
            outSh_q <= e1_tx_pkg::IDLE_BYTE;
            lineSlot_q <= e1_tx_pkg::TS_SIG;
            lineFrame_q <= e1_tx_pkg::FRAME_RESET;
            crc_q <= e1_tx_pkg::CRC_INIT;
            crcHold_q <= e1_tx_pkg::CRC_INIT;
            lineOut_q <= '{data: 1'b1, mfStart: 1'b0, ts0: 1'b0};
        end else begin
            loadArm_q <= loadArm_d;
            outSh_q <= outSh_d;
            lineSlot_q <= lineSlot_d;
            lineFrame_q <= lineFrame_d;
            crc_q <= crc_d;
            crcHold_q <= crcHold_d;
            lineOut_q <= lineOut_d;
        end
    end

    assign lineOut = lineOut_q;
    assign lineBitStrobe = riseEdge;
    assign ccsModeActive = ccsMode_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic loadSync, byteEnd;
    logic [3:0] ts0Cells_q, ts0Cells_d;
    assign loadSync = riseEdge && loadArm_q && slot0;
    assign byteEnd = fallEdge && bitPos_q[2:0] == e1_tx_pkg::LAST_BIT;

    // Helper count of line bit cells spent in timeslot 0
    always_comb begin
        ts0Cells_d = ts0Cells_q;
        if (riseEdge) begin
            ts0Cells_d = lineOut_d.ts0 ? ts0Cells_q + 4'h1 : '0;
        end
    end

    // Helper register, cleared by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            ts0Cells_q <= '0;
        end else begin
            ts0Cells_q <= ts0Cells_d;
        end
    end

    // Timeslot 0 content, checked one clk after the byte loads, and timeslot 0 length, checked as it ends
    a_fas_pattern: assert property (loadSync && !newFrame[0] |=>
        lineOut_q.data == $past(cBit) && outSh_q[7:1] == e1_tx_pkg::FAS_WORD)
        else $error("FAS word wrong");
    a_nfas_fixed: assert property (loadSync && newFrame[0] |=>
        outSh_q[7] && outSh_q[5:1] == $past(nationalUseBits))
        else $error("odd frame bit 2 or national bits wrong");
    a_remote_alarm: assert property (loadSync && newFrame[0] |=>
        outSh_q[6] == $past(remoteAlarm))
        else $error("remote alarm bit wrong");
    a_mfas_seq: assert property (loadSync && newFrame[0] &&
        newFrame < e1_tx_pkg::FRAME_MFAS_END |=>
        lineOut_q.data == e1_tx_pkg::MFAS_WORD[e1_tx_pkg::MFAS_TOP - lineFrame_q[3:1]])
        else $error("multiframe alignment bit wrong");
    a_far_report: assert property (loadSync && newFrame == e1_tx_pkg::FRAME_REPORT_1
        |=> lineOut_q.data == $past(farEndReportFirst))
        else $error("first report bit wrong");
    a_far_second: assert property (loadSync && newFrame == e1_tx_pkg::FRAME_RESET
        |=> lineOut_q.data == $past(farEndReportSecond))
        else $error("second report bit wrong");
    a_mf_start: assert property (lineOut_q.mfStart
        |-> lineOut_q.ts0 && lineFrame_q == e1_tx_pkg::FRAME_FIRST)
        else $error("multiframe start outside frame 0");
    a_ts0_length: assert property (riseEdge && lineOut_q.ts0 && !lineOut_d.ts0
        |-> ts0Cells_q == 4'(e1_tx_pkg::BITS_PER_CHANNEL))
        else $error("timeslot 0 not eight bit cells long");
    a_crc_hold: assert property (loadSync && smfStart
        |=> crcHold_q == $past(crc_q) && lineFrame_q[2:0] == e1_tx_pkg::FRAME_FIRST[2:0])
        else $error("remainder not kept at submultiframe start");

    // Bus side capture and line timing
    a_sample_fall: assert property (fallEdge |=> dataSh_q[0] == $past(sync2_q.data))
        else $error("bus bit not sampled on fall");
    a_tx_rise: assert property ($changed(lineOut_q.data) |-> $past(riseEdge))
        else $error("line bit changed off a rising edge");
    a_ccs_copy: assert property (byteEnd && busChan == e1_tx_pkg::TS_SIG && ccsMode_q
        |=> nextByte_q == $past(dataShD))
        else $error("CCS channel altered");
    a_ccs_latch: assert property (byteEnd && busChan == e1_tx_pkg::CH_CTL_CCS
        |=> ccsMode_q == $past(ctl0ShD[e1_tx_pkg::CCS_BIT]))
        else $error("CCS mode not taken from channel 31");
    a_slot0_unused: assert property (byteEnd && busChan == e1_tx_pkg::TS_SYNC
        |=> nextByte_q == e1_tx_pkg::UNUSED_BYTE)
        else $error("bus channel 0 data not ignored");
    a_frame_restart: assert property (fallEdge && fpActive
        |=> bitPos_q == e1_tx_pkg::POS_FIRST)
        else $error("frame pulse did not restart channel 0");

    // Main scenarios
    c_ccs_on: cover property ($rose(ccsMode_q));
    c_mf_start: cover property (lineOut_q.mfStart);
    c_smf2: cover property (loadSync && newFrame == 4'h8);
    c_ccs_slot: cover property (byteEnd && busChan == e1_tx_pkg::TS_SIG && ccsMode_q);
    c_report_2: cover property (loadSync && newFrame == e1_tx_pkg::FRAME_RESET);

endmodule

// File: dv/bus_partner.sv
/* Behavioural system-side source of the serial bus: bit clock, frame pulse
   and the data and control streams.
   Assumes clk runs at eight times the bit clock and the bench supplies bytes. */
`timescale 1ns/1ns
module bus_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] dataByte,
    input wire logic [7:0] ctl0Byte,
    input wire logic [7:0] ctl1Byte,
    output e1_tx_pkg::bus_in_s busOut,
    output logic [7:0] pos,
    output int frame
);
    ////////////////////////////////////////////////////////////
    logic [2:0] phase;

    // Position steps one clk ahead of the rise so the bench bytes settle
    always @(negedge clk) begin
        if (rst) begin
            phase = 3'h0;
            pos = 8'hFD;
            frame = -1;
            busOut = 5'h1F; // Clock high, pulse off, lines high
        end else begin
            phase = phase + 3'h1;
            if (phase == 3'h4) busOut.bitClock = 1'b0;
            if (phase == 3'h7) begin
                pos = pos + 8'h01;
                if (pos == 8'h00) frame = frame + 1;
            end
            if (phase == 3'h0) begin
                busOut.bitClock = 1'b1;
                busOut.framePulseN = (pos != 8'hFF);
                busOut.data = dataByte[3'h7 - pos[2:0]];
                busOut.ctl0 = ctl0Byte[3'h7 - pos[2:0]];
                busOut.ctl1 = ctl1Byte[3'h7 - pos[2:0]];
            end
        end
    end
endmodule

// File: dv/testbench.sv
/* Self-checking bench for the E1 transmit frame assembler.
   Assumes the design package and the bus partner model are compiled first. */
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic repFirst = 1'b1;
    logic repSecond = 1'b1;
    logic remoteAlarm = 1'b0;
    logic [4:0] natBits = 5'h1F;
    e1_tx_pkg::bus_in_s busIn;
    e1_tx_pkg::line_out_s lineOut;
    logic lineBitStrobe;
    logic ccsModeActive;
    logic [7:0] pos;
    int frame;
    logic [7:0] dataMem [0:39][0:31];
    logic [7:0] ctl0Mem [0:39][0:31];
    logic [7:0] ctl1Mem [0:39][0:31];
    logic [31:0] seed = 32'h0001_7D28;
    int fails = 0;
    int cmpCount = 0;
    int lineFrame = 0;
    bit aligned = 1'b0;
    logic strobeD = 1'b0;
    logic [3:0] crc = 4'h0;
    logic [3:0] crcPrev = 4'h0;
    logic [7:0] ts0Exp = 8'h00;

    ////////////////////////////////////////////////////////////
    always #20 clk = ~clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic seen, input logic exp, input string what);
        cmpCount++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t %s seen %b expected %b", $time, what, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // Far side and design
    bus_partner i_partner (.clk(clk), .rst(rst), .busOut(busIn), .pos(pos), .frame(frame),
        .dataByte(dataMem[(frame + 40) % 40][pos[7:3]]),
        .ctl0Byte(ctl0Mem[(frame + 40) % 40][pos[7:3]]),
        .ctl1Byte(ctl1Mem[(frame + 40) % 40][pos[7:3]]));

    e1_crc4_tx_frame_assembler i_dut (.clk(clk), .rst(rst),
        .busBitClockIn(busIn.bitClock), .framePulseInN(busIn.framePulseN),
        .dataStreamIn(busIn.data), .controlStreamFirstIn(busIn.ctl0),
        .controlStreamSecondIn(busIn.ctl1), .farEndReportFirst(repFirst),
        .farEndReportSecond(repSecond), .remoteAlarm(remoteAlarm),
        .nationalUseBits(natBits), .lineOut(lineOut), .lineBitStrobe(lineBitStrobe),
        .ccsModeActive(ccsModeActive));

    ////////////////////////////////////////////////////////////
    // Reference model: once aligned on mfStart, predict each line bit cell one clk after its strobe
    always @(negedge clk) begin : model
        int slot;
        int bf;
        int b;
        int n;
        logic e;
        if (strobeD && !rst) begin
            b = pos[2:0];
            slot = (int'(pos[7:3]) + 31) % 32;
            bf = (((pos[7:3] == 5'h00) ? frame - 1 : frame) + 40) % 40;
            if (slot == 0 && b == 0) begin
                if (lineOut.mfStart === 1'b1 && !aligned) begin
                    aligned = 1'b1;
                    lineFrame = -1;
                end
                lineFrame++;
                n = lineFrame % 16;
                if (aligned && lineFrame % 8 == 0) begin
                    crcPrev = crc;
                    crc = 4'h0;
                end
                if (n % 2 == 0) ts0Exp = {crcPrev[3 - (n % 8) / 2], e1_tx_pkg::FAS_WORD};
                else if (n <= 11) ts0Exp = {e1_tx_pkg::MFAS_WORD[5 - (n - 1) / 2], 1'b1,
                    remoteAlarm, natBits};
                else ts0Exp = {(n == 13) ? repFirst : repSecond, 1'b1, remoteAlarm, natBits};
            end
            if (aligned) begin
                n = lineFrame % 16;
                check(lineOut.ts0, slot == 0, "slot zero marker");
                check(lineOut.mfStart, slot == 0 && b == 0 && n == 0, "mf start");
                if (slot == 0) begin
                    e = ts0Exp[7 - b];
                    // C bits of the first submultiframe hold a partial remainder
                    if (b == 0 && n % 2 == 0) begin
                        if (lineFrame >= 8) check(lineOut.data, e, "C bit");
                        e = 1'b0;
                    end else if (b == 0) begin
                        check(lineOut.data, e, "odd bit 1");
                    end else begin
                        check(lineOut.data, e, "slot zero bit");
                    end
                end else if (slot == 16) begin
                    e = ctl0Mem[(bf + 39) % 40][31][e1_tx_pkg::CCS_BIT];
                    check(ccsModeActive, e, "ccs mode");
                    e = e ? dataMem[bf][16][7 - b] : ctl1Mem[bf][16][7 - b];
                    check(lineOut.data, e, "slot 16 bit");
                end else begin
                    e = dataMem[bf][slot][7 - b];
                    check(lineOut.data, e, "channel bit");
                end
                crc = {crc[2:0], 1'b0} ^ ((crc[3] ^ e) ? 4'h3 : 4'h0);
            end
            if (slot == 8 && b == 0) begin
                seed = lfsr_next(seed);
                {repFirst, repSecond, remoteAlarm, natBits} = seed[7:0];
            end
        end
        strobeD = lineBitStrobe;
    end

    ////////////////////////////////////////////////////////////
    // Main sequence: random bus content, reset, then run 36 bus frames
    initial begin
        for (int f = 0; f < 40; f++) begin
            for (int c = 0; c < 32; c++) begin
                seed = lfsr_next(seed);
                dataMem[f][c] = seed[7:0];
                ctl0Mem[f][c] = seed[15:8];
                ctl1Mem[f][c] = seed[23:16];
            end
        end
        ctl0Mem[39][31] = 8'h00;
        repeat (4) @(posedge clk);
        @(negedge clk) rst <= 1'b0;
        check(ccsModeActive, 1'b0, "ccs after reset");
        while (frame < 36) @(posedge clk);
        check(aligned && lineFrame >= 24, 1'b1, "multiframes reached");
        close_out();
    end

    // Watchdog: 36 frames of 2048 clocks plus margin
    initial begin
        #3_200_000;
        fails++;
        close_out();
    end
endmodule
